// ---- rtl/rmwr_reply.sv ----
`timescale 1ns/100ps
`default_nettype none
module rmwr_reply #(
  parameter int PATH_MAX = rmwr_pkg::MAX_PATH
) (
  input  wire logic                  mclk_i,
  input  wire logic                  arst_n_i,
  // command verdict, one pulse per finished command
  input  wire logic                  cmd_done_i,
  input  wire rmwr_pkg::rmwr_cmd_t   cmd_i,
  input  wire rmwr_pkg::rmwr_err_t   err_i,
  input  wire logic                  in_data_i,
  // source path bytes as supplied, first byte in [0]
  input  wire logic [PATH_MAX*8-1:0] path_i,
  output logic                       cmd_ready_o,
  output logic                       reg_write_o,
  output rmwr_pkg::rmwr_err_t        err_flags_o,
  input  wire logic                  err_clr_i,
  // reply stream
  output logic                       tx_valid_o,
  input  wire logic                  tx_ready_i,
  output rmwr_pkg::rmwr_byte_t       tx_byte_o
);

  // path buffer holds whole four-byte words only
  if (PATH_MAX < 4 || PATH_MAX > rmwr_pkg::MAX_PATH || (PATH_MAX % 4) != 0)
  begin : g_bad_path
    $error("path buffer must hold one to three four-byte words");
  end

  typedef enum logic [2:0] {S_IDLE, S_PATH, S_HDR, S_CRC} rmwr_state_t;

  typedef struct packed {
    rmwr_state_t           state;
    logic [PATH_MAX*8-1:0] path;
    logic [3:0]            plen;
    logic [3:0]            pidx;
    logic [2:0]            hidx;
    rmwr_pkg::rmwr_cmd_t   cmd;
    logic [7:0]            status;
    logic [7:0]            crc;
    logic                  wr;
    rmwr_pkg::rmwr_err_t   flags;
    rmwr_pkg::rmwr_byte_t  buf0;
    rmwr_pkg::rmwr_byte_t  buf1;
    logic [1:0]            cnt;
    logic                  rdy;
    logic                  valid;
  } rmwr_regs_t;

  rmwr_regs_t q, d;
  logic [1:0] rst_sync_q;
  logic       rst_n;
  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // error priority
  // ************************************************************
  function automatic logic [8:0] rmwr_verdict(input rmwr_pkg::rmwr_err_t e,
                                              input logic dpart);
    // {reply, status}
    if (e.hdr_crc || e.proto || e.src_laddr || e.path_seq) return {1'b0, 8'h00}; // RULE_11 RULE_12 RULE_13
    if (e.dest_laddr) return {1'b1, rmwr_pkg::ST_DLADDR}; // RULE_22
    if (e.unused_cmd) return {1'b1, rmwr_pkg::ST_UNUSED}; // RULE_14
    if (e.not_impl || e.reg_addr) return {1'b1, rmwr_pkg::ST_NOTIMPL}; // RULE_21
    if (e.dest_key) return {1'b1, rmwr_pkg::ST_KEY}; // RULE_15
    if (e.verify_ovr) return {1'b1, rmwr_pkg::ST_VERIFY}; // RULE_19
    if (e.rmw_len) return {1'b1, rmwr_pkg::ST_RMWLEN}; // RULE_22
    if (e.data_len) return {1'b1, rmwr_pkg::ST_NOTIMPL}; // RULE_20
    if (e.early_eop) return {dpart, rmwr_pkg::ST_EOP}; // RULE_17
    if (e.early_eep) return {dpart, rmwr_pkg::ST_EEP}; // RULE_17
    if (e.data_crc) return {1'b1, rmwr_pkg::ST_DCRC}; // RULE_16
    if (e.cargo_big) return {1'b1, rmwr_pkg::ST_CARGO}; // RULE_18
    return {1'b1, rmwr_pkg::ST_OK}; // RULE_26
  endfunction : rmwr_verdict

  logic [8:0]           verdict;
  logic [3:0]           plen_in;
  logic [7:0]           hdr_byte;
  logic [7:0]           pbyte;
  logic [3:0]           first_nz;
  rmwr_pkg::rmwr_byte_t nb;
  logic                 push;
  logic                 pop;
  logic                 can_push;

  assign verdict  = rmwr_verdict(err_i, in_data_i);
  // path bytes announced by the command, four per word
  assign plen_in  = {cmd_i.path_words[1:0], 2'b00}; // RULE_02
  assign pop      = tx_ready_i && (q.cnt != 2'd0);
  assign can_push = (q.cnt != 2'd2) || pop;

  always_comb
  begin
    first_nz = 4'(PATH_MAX);
    for (int i = PATH_MAX - 1; i >= 0; i--)
    begin
      if (i < int'(plen_in) && path_i[i*8 +: 8] != 8'h00)
        first_nz = 4'(i);
    end
  end

  always_comb
  begin
    pbyte = q.path[q.pidx*8 +: 8];
    unique case (q.hidx)
      3'd0: hdr_byte = q.cmd.init_laddr; // RULE_03
      3'd1: hdr_byte = rmwr_pkg::PROTO_ID; // RULE_04
      3'd2: hdr_byte = rmwr_pkg::REPLY_CMD; // RULE_05
      3'd3: hdr_byte = q.status; // RULE_06
      3'd4: hdr_byte = rmwr_pkg::RESP_LADDR; // RULE_07
      3'd5: hdr_byte = q.cmd.trans_id[15:8]; // RULE_08
      default: hdr_byte = q.cmd.trans_id[7:0]; // RULE_08
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    d          = q;
    d.wr       = 1'b0;
    push       = 1'b0;
    nb         = '{data: 8'h00, eop: 1'b0, port: q.cmd.port}; // RULE_01
    if (err_clr_i)
      d.flags = '0;
    if (cmd_done_i)
      d.flags = d.flags | err_i; // RULE_10
    unique case (q.state)
      S_IDLE:
      begin
        if (cmd_done_i && q.rdy)
        begin
          d.cmd    = cmd_i;
          d.path   = path_i;
          d.status = verdict[7:0];
          d.wr     = verdict[8] && (verdict[7:0] == rmwr_pkg::ST_OK); // RULE_15
          d.pidx   = first_nz; // RULE_24
          d.plen   = plen_in;
          d.hidx   = 3'd0;
          d.crc    = rmwr_pkg::CRC_INIT; // RULE_23
          if (verdict[8])
            d.state = (first_nz < plen_in) ? S_PATH : S_HDR; // RULE_02
        end
      end
      S_PATH:
      begin
        if (can_push)
        begin
          push    = 1'b1;
          nb.data = pbyte; // RULE_02
          d.pidx  = q.pidx + 4'd1;
          if (q.pidx + 4'd1 == q.plen)
            d.state = S_HDR;
        end
      end
      S_HDR:
      begin
        if (can_push)
        begin
          push    = 1'b1;
          nb.data = hdr_byte;
          d.crc   = rmwr_pkg::crc8_step(q.crc, hdr_byte); // RULE_09
          d.hidx  = q.hidx + 3'd1;
          if (q.hidx == 3'd6)
            d.state = S_CRC;
        end
      end
      S_CRC:
      begin
        if (can_push)
        begin
          push    = 1'b1;
          nb.data = q.crc; // RULE_09
          nb.eop  = 1'b1; // RULE_25
          d.state = S_IDLE;
        end
      end
      default: d.state = S_IDLE;
    endcase
    // two-entry output buffer
    if (pop)
    begin
      d.buf0 = q.buf1;
      d.cnt  = q.cnt - 2'd1;
    end
    if (push)
    begin
      if (d.cnt == 2'd0)
        d.buf0 = nb;
      else
        d.buf1 = nb;
      d.cnt = d.cnt + 2'd1;
    end
    d.valid = (d.cnt != 2'd0);
    // new command only once the buffer is drained, so buffered bytes keep their port
    d.rdy   = (d.state == S_IDLE) && (d.cnt == 2'd0); // RULE_01
  end

  // reset release through two flops
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.state  <= S_IDLE;
      q.path   <= '0;
      q.plen   <= 4'd0;
      q.pidx   <= 4'd0;
      q.hidx   <= 3'd0;
      q.cmd    <= '0;
      q.status <= rmwr_pkg::ST_OK;
      q.crc    <= rmwr_pkg::CRC_INIT;
      q.wr     <= 1'b0;
      q.flags  <= '0;
      q.buf0   <= '0;
      q.buf1   <= '0;
      q.cnt    <= 2'd0;
      q.rdy    <= 1'b0;
      q.valid  <= 1'b0;
    end
    else
    begin
      q.state  <= d.state;
      q.path   <= d.path;
      q.plen   <= d.plen;
      q.pidx   <= d.pidx;
      q.hidx   <= d.hidx;
      q.cmd    <= d.cmd;
      q.status <= d.status;
      q.crc    <= d.crc;
      q.wr     <= d.wr;
      q.flags  <= d.flags;
      q.buf0   <= d.buf0;
      q.buf1   <= d.buf1;
      q.cnt    <= d.cnt;
      q.rdy    <= d.rdy;
      q.valid  <= d.valid;
    end
  end

  assign cmd_ready_o = q.rdy;
  assign reg_write_o = q.wr;
  assign err_flags_o = q.flags;
  assign tx_valid_o  = q.valid;
  assign tx_byte_o   = q.buf0;

  // ************************************************************
  // checks
  // ************************************************************
  a_no_reply_hdr: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_11
    (cmd_done_i && q.state == S_IDLE && err_i.hdr_crc) |=> (q.state == S_IDLE))
    else $error("reply started after header check failure");
  a_no_reply_src: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_12
    (cmd_done_i && q.state == S_IDLE && err_i.src_laddr) |=> (q.state == S_IDLE))
    else $error("reply started after bad initiator address");
  a_no_reply_path: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_13
    (cmd_done_i && q.state == S_IDLE && err_i.path_seq) |=> !q.wr && q.state == S_IDLE)
    else $error("reply started after path sequence error");
  a_flag_record: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_10
    (cmd_done_i && err_i.dest_key) |=> q.flags.dest_key)
    else $error("error flag not recorded");
  a_key_status: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_15
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{dest_key: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_KEY && !q.wr)
    else $error("key mismatch status wrong");
  a_eop_ends: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_25
    (q.state == S_CRC && can_push)
      |=> (q.cnt == 2'd1 && q.buf0.eop) || (q.cnt == 2'd2 && q.buf1.eop))
    else $error("reply end marker missing");
  a_hdr_len: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_09
    (q.state == S_HDR && q.hidx == 3'd6 && can_push) |=> q.state == S_CRC)
    else $error("header length wrong");
  a_port_same: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_01
    tx_valid_o |-> tx_byte_o.port == q.cmd.port)
    else $error("reply on wrong port");
  a_resp_addr: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_07
    (q.state == S_HDR && q.hidx == 3'd4) |-> hdr_byte == 8'hFE)
    else $error("responder address wrong");

  // ************************************************************
  // status, suppression, flag hold, check code start and path byte checks
  // ************************************************************
  a_key_no_write: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_15
    (cmd_done_i && q.rdy && err_i.dest_key) |=> !reg_write_o)
    else $error("register written despite key mismatch");
  a_ok_write: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_06
    (cmd_done_i && q.rdy && err_i == '0)
      |=> reg_write_o && q.status == rmwr_pkg::ST_OK)
    else $error("clean command not written or status wrong");
  a_proto_drop: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_11
    (cmd_done_i && q.rdy && err_i.proto) |=> q.state == S_IDLE && !reg_write_o)
    else $error("reply started after protocol error");
  a_unused_st: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_14
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{unused_cmd: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_UNUSED)
    else $error("unused command status wrong");
  a_dcrc_st: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_16
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{data_crc: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_DCRC)
    else $error("data check status wrong");
  a_cargo_st: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_18
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{cargo_big: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_CARGO)
    else $error("cargo status wrong");
  a_verify_st: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_19
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{verify_ovr: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_VERIFY)
    else $error("verify overrun status wrong");
  a_len_st: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_20
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{data_len: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_NOTIMPL)
    else $error("data length status wrong");
  a_reg_st: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_21
    (cmd_done_i && q.rdy && err_i == rmwr_pkg::rmwr_err_t'{reg_addr: 1'b1, default: 1'b0})
      |=> q.status == rmwr_pkg::ST_NOTIMPL)
    else $error("register address status wrong");
  a_dladdr_first: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_22 RULE_26
    (cmd_done_i && q.rdy && err_i.dest_laddr
      && !(err_i.hdr_crc || err_i.proto || err_i.src_laddr || err_i.path_seq))
      |=> q.status == rmwr_pkg::ST_DLADDR)
    else $error("target address status not first");
  a_eep_outside: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_17
    (cmd_done_i && q.rdy && !in_data_i
      && err_i == rmwr_pkg::rmwr_err_t'{early_eep: 1'b1, default: 1'b0})
      |=> q.state == S_IDLE)
    else $error("reply started after early end outside data");
  a_eop_inside: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_17
    (cmd_done_i && q.rdy && in_data_i
      && err_i == rmwr_pkg::rmwr_err_t'{early_eop: 1'b1, default: 1'b0})
      |=> q.state != S_IDLE && q.status == rmwr_pkg::ST_EOP)
    else $error("early end in data part not answered");
  a_flag_hold: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_10
    (q.flags.hdr_crc && !err_clr_i) |=> q.flags.hdr_crc)
    else $error("error flag lost without clear");
  a_crc_start: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_23
    (q.state == S_HDR && q.hidx == 3'd0) |-> q.crc == rmwr_pkg::CRC_INIT)
    else $error("header check not started from initial value");
  a_path_nonzero: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_24
    (q.state == S_PATH) |-> pbyte != 8'h00)
    else $error("zero path byte sent");

endmodule : rmwr_reply
`default_nettype wire

// ---- rtl/rmwr_pkg.sv ----
// Contract
// RULE_01: reply leaves by the router port on which the command arrived
// RULE_02: reply opens with the command's source path bytes, if any
// RULE_03: initiator logical address follows the path bytes
// RULE_04: protocol identifier 01h follows the initiator logical address
// RULE_05: command byte marks a single-address write reply packet
// RULE_06: one status byte carries success or the detected error code
// RULE_07: responder logical address field is always FEh
// RULE_08: two-byte transaction identifier is copied unchanged
// RULE_09: header check code over preceding reply bytes ends the header; the code leaves the path bytes out of it
// RULE_10: every detected command error raises a status flag
// RULE_11: bad header check or protocol identifier: flag, no reply
// RULE_12: initiator logical address below 20h: flag, no reply
// RULE_13: invalid source path sequence: flag, no reply
// RULE_14: unused command code or packet type replies status 2
// RULE_15: destination key mismatch replies status 3, no register write
// RULE_16: bad data check code replies status 4
// RULE_17: early end marker status 5, error end 7; reply only in data part
// RULE_18: cargo complete without end marker replies status 6
// RULE_19: verified write length not 4 replies status 9
// RULE_20: zero, non multiple of 4 or bad read length replies status 10
// RULE_21: unsupported command, unknown or read-only register replies 10
// RULE_22: read-modify-write length not 8 replies 11; bad target address 12
// RULE_23: check codes use x^8+x^2+x+1 starting from 00h
// RULE_24: leading zero path bytes are dropped from the reply
// RULE_25: reply ends with a normal end marker after the header check
// RULE_26: first error in byte order decides reply and status
package rmwr_pkg;

  localparam logic [7:0] PROTO_ID      = 8'h01;
  localparam logic [7:0] RESP_LADDR    = 8'hFE;
  localparam logic [7:0] MIN_INIT_ADDR = 8'h20;
  localparam logic [7:0] CRC_INIT      = 8'h00;
  localparam logic [7:0] CRC_POLY      = 8'h07;
  localparam logic [7:0] REPLY_CMD     = 8'h0C;
  localparam int         MAX_PATH      = 12;

  localparam logic [7:0] ST_OK         = 8'h00;
  localparam logic [7:0] ST_UNUSED     = 8'h02;
  localparam logic [7:0] ST_KEY        = 8'h03;
  localparam logic [7:0] ST_DCRC       = 8'h04;
  localparam logic [7:0] ST_EOP        = 8'h05;
  localparam logic [7:0] ST_CARGO      = 8'h06;
  localparam logic [7:0] ST_EEP        = 8'h07;
  localparam logic [7:0] ST_VERIFY     = 8'h09;
  localparam logic [7:0] ST_NOTIMPL    = 8'h0A;
  localparam logic [7:0] ST_RMWLEN     = 8'h0B;
  localparam logic [7:0] ST_DLADDR     = 8'h0C;

  // error flags, one per detected condition
  typedef struct packed {
    logic hdr_crc;
    logic proto;
    logic src_laddr;
    logic path_seq;
    logic unused_cmd;
    logic dest_key;
    logic data_crc;
    logic early_eop;
    logic cargo_big;
    logic early_eep;
    logic verify_ovr;
    logic not_impl;
    logic data_len;
    logic reg_addr;
    logic rmw_len;
    logic dest_laddr;
  } rmwr_err_t;

  // one reply byte with its end marker
  typedef struct packed {
    logic [7:0] data;
    logic       eop;
    logic [3:0] port;
  } rmwr_byte_t;

  // fields the command parser took from one command
  typedef struct packed {
    logic [3:0]  port;
    logic [7:0]  init_laddr;
    logic [7:0]  proto;
    logic [15:0] trans_id;
    logic [3:0]  path_words;
  } rmwr_cmd_t;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8_step

endpackage : rmwr_pkg

// ---- tb/rmwr_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
module rmwr_sink (
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 tx_valid_i,
  output logic                      tx_ready_o,
  input  wire rmwr_pkg::rmwr_byte_t tx_byte_i
);
  // ********************
  // initiator side
  // ********************
  // accepted reply bytes, oldest first
  rmwr_pkg::rmwr_byte_t got[$];

  initial tx_ready_o = 1'b0;

  // stalls about one cycle in three
  always @(negedge mclk_i)
  begin
    tx_ready_o <= arst_n_i && ($urandom_range(2) != 0);
  end

  always @(posedge mclk_i)
  begin
    if (tx_valid_i && tx_ready_o)
    begin
      got.push_back(tx_byte_i);
    end
  end
endmodule : rmwr_sink
`default_nettype wire

// ---- tb/rmap_write_reply_and_error_handler_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module rmap_write_reply_and_error_handler_test;
  // ********************
  // bench
  // ********************
  logic                 mclk_i      = 1'b0;
  logic                 arst_n_i    = 1'b0;
  logic                 cmd_done_i  = 1'b0;
  rmwr_pkg::rmwr_cmd_t  cmd_i       = '0;
  rmwr_pkg::rmwr_err_t  err_i       = '0;
  logic                 in_data_i   = 1'b0;
  logic [95:0]          path_i      = '0;
  logic                 err_clr_i   = 1'b0;
  logic                 tx_ready_i;
  logic                 cmd_ready_o;
  logic                 reg_write_o;
  logic                 tx_valid_o;
  rmwr_pkg::rmwr_err_t  err_flags_o;
  rmwr_pkg::rmwr_byte_t tx_byte_o;
  int                   errors      = 0;
  int                   comparisons = 0;
  int                   writes      = 0;

  always #10 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    if (reg_write_o === 1'b1)
    begin
      writes++;
    end
  end

  rmwr_reply u_rmwr_reply (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmd_done_i(cmd_done_i),
    .cmd_i(cmd_i), .err_i(err_i), .in_data_i(in_data_i), .path_i(path_i),
    .cmd_ready_o(cmd_ready_o), .reg_write_o(reg_write_o), .err_flags_o(err_flags_o),
    .err_clr_i(err_clr_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .tx_byte_o(tx_byte_o));

  rmwr_sink u_rmwr_sink (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .tx_byte_i(tx_byte_o));

  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // bit 8 set when a reply is due, low byte the status
  function automatic logic [8:0] expect_reply(logic [15:0] e, logic d);
    int         pri[12] = '{0, 11, 4, 2, 10, 5, 1, 3, 8, 6, 9, 7};
    logic [7:0] st[12]  = '{8'h0C, 8'h02, 8'h0A, 8'h0A, 8'h03, 8'h09, 8'h0B, 8'h0A,
                            8'h05, 8'h07, 8'h04, 8'h06};
    if (e[15:12] != 4'h0)
      return 9'h000;
    foreach (pri[k])
      if (e[pri[k]])
        return ((pri[k] == 8 || pri[k] == 6) && !d) ? 9'h000 : {1'b1, st[k]};
    return 9'h100;
  endfunction : expect_reply

  function automatic logic [7:0] crc(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    repeat (8) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction : crc

  task automatic run(logic [15:0] e, logic d, int w);
    logic [7:0] q[$];
    logic [8:0] x;
    logic [7:0] c;
    int         z;
    int         n;
    int         w0;
    x = expect_reply(e, d);
    cmd_i.port = 4'($urandom_range(15));
    cmd_i.init_laddr = 8'($urandom_range(8'hFF, 8'h20));
    cmd_i.proto = 8'h01;
    cmd_i.trans_id = 16'($urandom);
    cmd_i.path_words = 4'(w);
    path_i = '0;
    z = (w == 0) ? 0 : $urandom_range(w * 4 - 1);
    for (int i = z; i < w * 4; i++)
      path_i[i*8 +: 8] = 8'($urandom_range(8'hFF, 8'h01));
    for (int i = z; i < w * 4; i++)
      q.push_back(path_i[i*8 +: 8]);
    n = q.size();
    q.push_back(cmd_i.init_laddr);
    q.push_back(8'h01);
    q.push_back(8'h0C);
    q.push_back(x[7:0]);
    q.push_back(8'hFE);
    q.push_back(cmd_i.trans_id[15:8]);
    q.push_back(cmd_i.trans_id[7:0]);
    c = 8'h00;
    for (int i = n; i < q.size(); i++)
      c = crc(c, q[i]);
    q.push_back(c);
    check("ready", cmd_ready_o, 1);
    err_i = e;
    in_data_i = d;
    cmd_done_i = 1'b1;
    w0 = writes;
    u_rmwr_sink.got.delete();
    @(negedge mclk_i);
    cmd_done_i = 1'b0;
    n = 0;
    while (n < 200 && !(x[8] && u_rmwr_sink.got.size() > 0 && u_rmwr_sink.got[$].eop))
    begin
      @(negedge mclk_i);
      n++;
    end
    check("reply", n < 200, x[8]);
    check("length", u_rmwr_sink.got.size(), x[8] ? q.size() : 0);
    foreach (u_rmwr_sink.got[k])
    begin
      check("byte", u_rmwr_sink.got[k].data, q[k]);
      check("port", u_rmwr_sink.got[k].port, cmd_i.port);
      check("eop", u_rmwr_sink.got[k].eop, k == q.size() - 1);
    end
    check("write", writes - w0, x == 9'h100);
    check("flags", err_flags_o, e);
    err_clr_i = 1'b1;
    @(negedge mclk_i);
    err_clr_i = 1'b0;
    check("cleared", err_flags_o, 0);
  endtask : run

  initial
  begin
    void'($urandom(32'hE0E5));
    repeat (16) @(negedge mclk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    // every error alone, status table
    for (int i = 0; i < 16; i++)
      run(16'h0001 << i, 1'b1, i % 4);
    run(16'h0100, 1'b0, 1);
    run(16'h0040, 1'b0, 3);
    run(16'h8400, 1'b1, 2);
    for (int i = 0; i < 40; i++)
      run(i[0] ? 16'h0000 : 16'($urandom) & 16'h0EBF, 1'b1, $urandom_range(3));
    stop_test();
  end
endmodule : rmap_write_reply_and_error_handler_test
`default_nettype wire
